// ### design/ldf_pkg.sv
// Package of register indices, field positions and reset values for the link diagnostic bank.
package ldf_pkg;

   // Register indices; the byte address of each register is four times its index.
   localparam logic [7:0]  PAGE_SELECT_IDX     = 8'h13;
   localparam logic [7:0]  CABLE_LENGTH_IDX    = 8'h14;
   localparam logic [7:0]  FREQ_OFFSET_IDX     = 8'h15;

   // Page selection field and the code that opens the diagnostic page.
   localparam int          PAGE_FIELD_LSB      = 0;
   localparam int          PAGE_FIELD_MSB      = 1;
   localparam logic [1:0]  DIAG_PAGE_CODE      = 2'h2;
   localparam logic [1:0]  PAGE_RESET          = 2'h0;

   // Field positions inside the frequency offset indication register.
   localparam int          SAMPLE_REQ_BIT      = 15;
   localparam int          VALUE_SELECT_BIT    = 8;
   localparam int          VALUE_FIELD_MSB     = 7;

   // Reset values and the marker for an unknown cable length.
   localparam logic [7:0]  LENGTH_RESET        = 8'h00;
   localparam logic [7:0]  LENGTH_UNKNOWN      = 8'hFF;
   localparam logic [7:0]  OFFSET_RESET        = 8'h00;
   localparam logic [15:0] REG_RESET           = 16'h0000;

   // AXI4-Lite response codes.
   localparam logic [1:0]  RESP_OKAY           = 2'b00;
   localparam logic [1:0]  RESP_SLVERR         = 2'b10;

   // Address width of the register window.
   localparam int          ADDR_W              = 12;

endpackage : ldf_pkg

// ### design/ldf_regs.sv
// Link diagnostic cable length and frequency offset registers behind an AXI4-Lite slave.
//
// Added by the designer: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none

module ldf_regs (
   // Clock and reset.
   input  wire  logic                      ref_clk_i,
   input  wire  logic                      rst_i,
   // AXI4-Lite write address channel.
   input  wire  logic [ldf_pkg::ADDR_W-1:0] s_axi_awaddr_i,
   input  wire  logic                      s_axi_awvalid_i,
   output logic                            s_axi_awready_o,
   // AXI4-Lite write data channel.
   input  wire  logic [31:0]               s_axi_wdata_i,
   input  wire  logic [3:0]                s_axi_wstrb_i,
   input  wire  logic                      s_axi_wvalid_i,
   output logic                            s_axi_wready_o,
   // AXI4-Lite write response channel.
   output logic [1:0]                      s_axi_bresp_o,
   output logic                            s_axi_bvalid_o,
   input  wire  logic                      s_axi_bready_i,
   // AXI4-Lite read address channel.
   input  wire  logic [ldf_pkg::ADDR_W-1:0] s_axi_araddr_i,
   input  wire  logic                      s_axi_arvalid_i,
   output logic                            s_axi_arready_o,
   // AXI4-Lite read data channel.
   output logic [31:0]                     s_axi_rdata_o,
   output logic [1:0]                      s_axi_rresp_o,
   output logic                            s_axi_rvalid_o,
   input  wire  logic                      s_axi_rready_i,
   // Link state from the receive path.
   input  wire  logic                      link_up_i,
   input  wire  logic                      speed_100_i,
   input  wire  logic [7:0]                length_estimate_i,
   input  wire  logic                      length_estimate_valid_i,
   // Receive signal processor fetch port.
   output logic                            dsp_req_o,
   output logic                            dsp_value_select_o,
   input  wire  logic                      dsp_ack_i,
   input  wire  logic [7:0]                dsp_offset_i,
   input  wire  logic [7:0]                dsp_phase_corr_i,
   // Current page selection, for the rest of the management logic.
   output logic [1:0]                      register_page_select_o
);

   // Bus channel state.
   logic                      awready_reg;
   logic                      awready_next;
   logic                      wready_reg;
   logic                      wready_next;
   logic                      aw_held_reg;
   logic                      aw_held_next;
   logic                      w_held_reg;
   logic                      w_held_next;
   logic                      bvalid_reg;
   logic                      bvalid_next;
   logic [1:0]                bresp_reg;
   logic                      arready_reg;
   logic                      arready_next;
   logic                      rvalid_reg;
   logic                      rvalid_next;
   logic [1:0]                rresp_reg;
   logic [31:0]               rdata_reg;
   logic [ldf_pkg::ADDR_W-1:0] awaddr_reg;
   logic [31:0]               wdata_reg;
   logic [3:0]                wstrb_reg;

   // Register contents and fetch state.
   logic [1:0]                page_reg;
   logic [7:0]                length_reg;
   logic [7:0]                length_next;
   logic                      control_value_select_reg;
   logic [7:0]                offset_reg;
   logic                      req_reg;
   logic                      req_sel_reg;

   // Channel handshakes.
   wire                       aw_take  = s_axi_awvalid_i & awready_reg;
   wire                       w_take   = s_axi_wvalid_i & wready_reg;
   wire                       b_done   = bvalid_reg & s_axi_bready_i;
   wire                       ar_take  = s_axi_arvalid_i & arready_reg;
   wire                       r_done   = rvalid_reg & s_axi_rready_i;
   wire                       do_write = aw_held_reg & w_held_reg & ~bvalid_reg;

   wire                       diag_page = (page_reg == ldf_pkg::DIAG_PAGE_CODE);

   // Write address decode; the diagnostic pair answers only while its page is open.
   wire [7:0]                 wr_idx     = awaddr_reg[9:2];
   wire                       wr_high_ok = (awaddr_reg[ldf_pkg::ADDR_W-1:10] == '0);
   wire                       wr_page    = wr_high_ok & (wr_idx == ldf_pkg::PAGE_SELECT_IDX);
   wire                       wr_len     = wr_high_ok & diag_page
                                           & (wr_idx == ldf_pkg::CABLE_LENGTH_IDX);
   wire                       wr_freq    = wr_high_ok & diag_page
                                           & (wr_idx == ldf_pkg::FREQ_OFFSET_IDX);
   wire                       wr_hit     = wr_page | wr_len | wr_freq;

   // Byte lane qualified writes to the frequency register.
   wire                       freq_hi_we = do_write & wr_freq & wstrb_reg[1];
   wire                       new_sel    = wdata_reg[ldf_pkg::VALUE_SELECT_BIT];
   wire                       sample_go  = freq_hi_we & wdata_reg[ldf_pkg::SAMPLE_REQ_BIT]
                                           & ~req_reg;

   // Read address decode.
   wire [7:0]                 rd_idx     = s_axi_araddr_i[9:2];
   wire                       rd_high_ok = (s_axi_araddr_i[ldf_pkg::ADDR_W-1:10] == '0);
   wire                       rd_page    = rd_high_ok & (rd_idx == ldf_pkg::PAGE_SELECT_IDX);
   wire                       rd_len     = rd_high_ok & diag_page
                                           & (rd_idx == ldf_pkg::CABLE_LENGTH_IDX);
   wire                       rd_freq    = rd_high_ok & diag_page
                                           & (rd_idx == ldf_pkg::FREQ_OFFSET_IDX);
   wire                       rd_hit     = rd_page | rd_len | rd_freq;

   wire [15:0]                page_word  = {14'h0000, page_reg};
   wire [15:0]                len_word   = {8'h00, length_reg};
   wire [15:0]                freq_word  = {1'b0, 6'h00, control_value_select_reg,
                                            offset_reg};
   wire [15:0]                rd_word    = rd_page ? page_word
                                           : rd_len ? len_word
                                           : rd_freq ? freq_word
                                           : ldf_pkg::REG_RESET;

   wire [7:0]                 ctrl_value = dsp_offset_i + dsp_phase_corr_i;
   wire [7:0]                 fetched    = req_sel_reg ? ctrl_value : dsp_offset_i;

   // Write channel bookkeeping; a channel stays closed while its item waits or a response is out.
   always_comb begin
      aw_held_next = aw_held_reg;
      w_held_next  = w_held_reg;
      bvalid_next  = bvalid_reg;
      if (aw_take) begin
         aw_held_next = 1'b1;
      end
      if (w_take) begin
         w_held_next = 1'b1;
      end
      if (do_write) begin
         aw_held_next = 1'b0;
         w_held_next  = 1'b0;
         bvalid_next  = 1'b1;
      end else if (b_done) begin
         bvalid_next = 1'b0;
      end
      awready_next = ~aw_held_next & ~bvalid_next;
      wready_next  = ~w_held_next & ~bvalid_next;
   end

   // Read channel bookkeeping; only one read is in flight at a time.
   always_comb begin
      rvalid_next = rvalid_reg;
      if (ar_take) begin
         rvalid_next = 1'b1;
      end else if (r_done) begin
         rvalid_next = 1'b0;
      end
      arready_next = ~rvalid_next;
   end

   always_comb begin
      if (speed_100_i & link_up_i & length_estimate_valid_i) begin
         length_next = length_estimate_i;
      end else begin
         length_next = ldf_pkg::LENGTH_UNKNOWN;
      end
   end

   // Handshake flops of the write side.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         awready_reg <= 1'b0;
         wready_reg  <= 1'b0;
         aw_held_reg <= 1'b0;
         w_held_reg  <= 1'b0;
         bvalid_reg  <= 1'b0;
      end else begin
         awready_reg <= awready_next;
         wready_reg  <= wready_next;
         aw_held_reg <= aw_held_next;
         w_held_reg  <= w_held_next;
         bvalid_reg  <= bvalid_next;
      end
   end

   // Captured write payload and response code.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         awaddr_reg <= '0;
         wdata_reg  <= 32'h0000_0000;
         wstrb_reg  <= 4'h0;
         bresp_reg  <= ldf_pkg::RESP_OKAY;
      end else begin
         if (aw_take) begin
            awaddr_reg <= s_axi_awaddr_i;
         end
         if (w_take) begin
            wdata_reg <= s_axi_wdata_i;
            wstrb_reg <= s_axi_wstrb_i;
         end
         if (do_write) begin
            bresp_reg <= wr_hit ? ldf_pkg::RESP_OKAY : ldf_pkg::RESP_SLVERR;
         end
      end
   end

   // Read side; data are sampled at the address handshake and held until taken.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         arready_reg <= 1'b0;
         rvalid_reg  <= 1'b0;
         rdata_reg   <= 32'h0000_0000;
         rresp_reg   <= ldf_pkg::RESP_OKAY;
      end else begin
         arready_reg <= arready_next;
         rvalid_reg  <= rvalid_next;
         if (ar_take) begin
            rdata_reg <= {16'h0000, rd_word};
            rresp_reg <= rd_hit ? ldf_pkg::RESP_OKAY : ldf_pkg::RESP_SLVERR;
         end
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         page_reg <= ldf_pkg::PAGE_RESET;
      end else if (do_write & wr_page & wstrb_reg[0]) begin
         page_reg <= wdata_reg[ldf_pkg::PAGE_FIELD_MSB:ldf_pkg::PAGE_FIELD_LSB];
      end
   end

   // Length is resampled every cycle so a read sees the link state of the cycle before its address handshake.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         length_reg <= ldf_pkg::LENGTH_RESET;
      end else begin
         length_reg <= length_next;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         control_value_select_reg <= 1'b0;
      end else if (freq_hi_we) begin
         control_value_select_reg <= new_sel;
      end
   end

   // Fetch request is held until the processor acknowledges; a new sample while busy is dropped.
   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         req_reg     <= 1'b0;
         req_sel_reg <= 1'b0;
      end else if (sample_go) begin
         req_reg     <= 1'b1;
         req_sel_reg <= new_sel;
      end else if (dsp_ack_i) begin
         req_reg <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk_i or posedge rst_i) begin
      if (rst_i) begin
         offset_reg <= ldf_pkg::OFFSET_RESET;
      end else if (req_reg & dsp_ack_i) begin
         offset_reg <= fetched;
      end
   end

   // Outputs straight from flops.
   assign s_axi_awready_o        = awready_reg;
   assign s_axi_wready_o         = wready_reg;
   assign s_axi_bvalid_o         = bvalid_reg;
   assign s_axi_bresp_o          = bresp_reg;
   assign s_axi_arready_o        = arready_reg;
   assign s_axi_rvalid_o         = rvalid_reg;
   assign s_axi_rdata_o          = rdata_reg;
   assign s_axi_rresp_o          = rresp_reg;
   assign dsp_req_o              = req_reg;
   assign dsp_value_select_o     = req_sel_reg;
   assign register_page_select_o = page_reg;

endmodule : ldf_regs

`default_nettype wire

// ### tb/ldf_regs_asserts.sv
// Port checker for the link diagnostic register bank.
`timescale 1ns/1ps
`default_nettype none
module ldf_regs_asserts (
   // Clock and reset.
   input wire logic        ref_clk_i,
   input wire logic        rst_i,
   // Register bus handshakes.
   input wire logic        s_axi_awvalid_i,
   input wire logic        s_axi_awready_o,
   input wire logic        s_axi_wvalid_i,
   input wire logic        s_axi_wready_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0]  s_axi_rresp_o,
   // Signal processor fetch port.
   input wire logic        dsp_req_o,
   input wire logic        dsp_ack_i,
   input wire logic        dsp_value_select_o
);
   // All checks share the one clock; reset silences them.
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   sequence s_fetch_done;
      dsp_req_o && dsp_ack_i;
   endsequence
   sequence s_wr_take;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
   endsequence
   a_req_hold: assert property (dsp_req_o && !dsp_ack_i |=> dsp_req_o)
      else $error("fetch request dropped before its ack");
   a_req_done: assert property (s_fetch_done |=> !dsp_req_o)
      else $error("fetch request still high after its load");
   a_sel_stable: assert property (dsp_req_o && !dsp_ack_i |=> $stable(dsp_value_select_o))
      else $error("value select moved during a fetch");
   a_rsv_zero: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:9] == 23'h00_0000)
      else $error("reserved or trigger bits read nonzero");
   a_err_nodata: assert property (s_axi_rvalid_o && s_axi_rresp_o == ldf_pkg::RESP_SLVERR
      |-> s_axi_rdata_o == 32'h0000_0000)
      else $error("refused read returned data");
   a_r_hold: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o
      && $stable(s_axi_rdata_o))
      else $error("read data not held until taken");
   a_rd_answer: assert property (s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o)
      else $error("read answer late");
   a_wr_answer: assert property (s_wr_take |-> ##[1:2] s_axi_bvalid_o)
      else $error("write answer late");
   a_b_hold: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o)
      else $error("write answer withdrawn");
endmodule : ldf_regs_asserts
bind ldf_regs ldf_regs_asserts u_chk (
   .ref_clk_i          (ref_clk_i),
   .rst_i              (rst_i),
   .s_axi_awvalid_i    (s_axi_awvalid_i),
   .s_axi_awready_o    (s_axi_awready_o),
   .s_axi_wvalid_i     (s_axi_wvalid_i),
   .s_axi_wready_o     (s_axi_wready_o),
   .s_axi_bvalid_o     (s_axi_bvalid_o),
   .s_axi_bready_i     (s_axi_bready_i),
   .s_axi_arvalid_i    (s_axi_arvalid_i),
   .s_axi_arready_o    (s_axi_arready_o),
   .s_axi_rvalid_o     (s_axi_rvalid_o),
   .s_axi_rready_i     (s_axi_rready_i),
   .s_axi_rdata_o      (s_axi_rdata_o),
   .s_axi_rresp_o      (s_axi_rresp_o),
   .dsp_req_o          (dsp_req_o),
   .dsp_ack_i          (dsp_ack_i),
   .dsp_value_select_o (dsp_value_select_o)
);
`default_nettype wire

// ### tb/ldf_regs_tb.sv
// Self-checking bench for the link diagnostic register bank.
`timescale 1ns/1ps
`default_nettype none
module ldf_regs_tb;
   // Bench signals carry the names of the ports they meet.
   logic ref_clk_i, rst_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i;
   logic s_axi_rready_i, link_up_i, speed_100_i, length_estimate_valid_i, dsp_ack_i;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
   logic dsp_req_o, dsp_value_select_o;
   logic [11:0] s_axi_awaddr_i, s_axi_araddr_i;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o, rd;
   logic [3:0]  s_axi_wstrb_i;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o, register_page_select_o, rsp;
   logic [7:0]  length_estimate_i, dsp_offset_i, dsp_phase_corr_i;
   int          errors, compares;
   ldf_regs u_dut (
      .ref_clk_i               (ref_clk_i),
      .rst_i                   (rst_i),
      .s_axi_awaddr_i          (s_axi_awaddr_i),
      .s_axi_awvalid_i         (s_axi_awvalid_i),
      .s_axi_awready_o         (s_axi_awready_o),
      .s_axi_wdata_i           (s_axi_wdata_i),
      .s_axi_wstrb_i           (s_axi_wstrb_i),
      .s_axi_wvalid_i          (s_axi_wvalid_i),
      .s_axi_wready_o          (s_axi_wready_o),
      .s_axi_bresp_o           (s_axi_bresp_o),
      .s_axi_bvalid_o          (s_axi_bvalid_o),
      .s_axi_bready_i          (s_axi_bready_i),
      .s_axi_araddr_i          (s_axi_araddr_i),
      .s_axi_arvalid_i         (s_axi_arvalid_i),
      .s_axi_arready_o         (s_axi_arready_o),
      .s_axi_rdata_o           (s_axi_rdata_o),
      .s_axi_rresp_o           (s_axi_rresp_o),
      .s_axi_rvalid_o          (s_axi_rvalid_o),
      .s_axi_rready_i          (s_axi_rready_i),
      .link_up_i               (link_up_i),
      .speed_100_i             (speed_100_i),
      .length_estimate_i       (length_estimate_i),
      .length_estimate_valid_i (length_estimate_valid_i),
      .dsp_req_o               (dsp_req_o),
      .dsp_value_select_o      (dsp_value_select_o),
      .dsp_ack_i               (dsp_ack_i),
      .dsp_offset_i            (dsp_offset_i),
      .dsp_phase_corr_i        (dsp_phase_corr_i),
      .register_page_select_o  (register_page_select_o)
   );
   // Free running 125 MHz clock.
   initial begin
      ref_clk_i = 1'b0;
      forever #4 ref_clk_i = ~ref_clk_i;
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chk_r(input string what, input logic [1:0] exp);
      chk(what, {30'h0, exp}, {30'h0, rsp});
   endtask : chk_r
   task automatic end_of_test();
      $display("compares %0d errors %0d", compares, errors);
      if (errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   task automatic limit(input int n);
      if (n >= 50) begin
         errors++;
         end_of_test();
      end
   endtask : limit
   // Write: address and data offered together, each released when taken.
   task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
      int n;
      @(posedge ref_clk_i);
      s_axi_awaddr_i  <= a;
      s_axi_wdata_i   <= d;
      s_axi_wstrb_i   <= s;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i  <= 1'b1;
      s_axi_bready_i  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk_i);
         if (s_axi_awready_o) s_axi_awvalid_i <= 1'b0;
         if (s_axi_wready_o) s_axi_wvalid_i <= 1'b0;
         if (s_axi_bvalid_o) break;
      end
      rsp = s_axi_bresp_o;
      s_axi_bready_i <= 1'b0;
      limit(n);
   endtask : wr
   task automatic rdr(input logic [11:0] a);
      int n;
      @(posedge ref_clk_i);
      s_axi_araddr_i  <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i  <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(posedge ref_clk_i);
         if (s_axi_arready_o) s_axi_arvalid_i <= 1'b0;
         if (s_axi_rvalid_o) break;
      end
      rd = s_axi_rdata_o;
      rsp = s_axi_rresp_o;
      s_axi_rready_i <= 1'b0;
      limit(n);
   endtask : rdr
   // Answers a pending fetch with a one cycle acknowledge.
   task automatic ack(input logic sel);
      int n;
      for (n = 0; n < 50 && dsp_req_o !== 1'b1; n++) @(posedge ref_clk_i);
      limit(n);
      chk("fetch select", {31'h0, sel}, {31'h0, dsp_value_select_o});
      dsp_ack_i <= 1'b1;
      @(posedge ref_clk_i);
      dsp_ack_i <= 1'b0;
   endtask : ack
   task automatic t_page();
      rdr(12'h04C);
      chk("page at reset", 32'h0, rd);
      rdr(12'h054);
      chk_r("freq on page 0", ldf_pkg::RESP_SLVERR);
      wr(12'h04C, 32'h0000_0001, 4'hF);
      chk_r("page write", ldf_pkg::RESP_OKAY);
      chk("page output", 32'h0000_0001, {30'h0, register_page_select_o});
      wr(12'h054, 32'h0000_8000, 4'hF);
      chk_r("freq write on page 1", ldf_pkg::RESP_SLVERR);
      chk("no fetch off page", 32'h0, {31'h0, dsp_req_o});
      rdr(12'h050);
      chk_r("length on page 1", ldf_pkg::RESP_SLVERR);
      wr(12'h04C, 32'h0000_0002, 4'hF);
      chk("page output two", 32'h0000_0002, {30'h0, register_page_select_o});
      rdr(12'h050);
      chk_r("length on page 2", ldf_pkg::RESP_OKAY);
      rdr(12'h010);
      chk_r("unmapped read", ldf_pkg::RESP_SLVERR);
      $display("test page done");
   endtask : t_page
   task automatic t_length();
      @(posedge ref_clk_i);
      length_estimate_i <= 8'h37;
      {link_up_i, speed_100_i, length_estimate_valid_i} <= 3'b111;
      wr(12'h050, 32'hFFFF_FFFF, 4'hF);
      chk_r("length write", ldf_pkg::RESP_OKAY);
      rdr(12'h050);
      chk("length qualified", 32'h0000_0037, rd);
      for (int i = 0; i < 3; i++) begin
         @(posedge ref_clk_i);
         {link_up_i, speed_100_i, length_estimate_valid_i} <= 3'b111 ^ (3'b001 << i);
         rdr(12'h050);
         chk("length unqualified", 32'h0000_00FF, rd);
      end
      $display("test length done");
   endtask : t_length
   task automatic t_freq();
      rdr(12'h054);
      chk("offset at reset", 32'h0, rd);
      @(posedge ref_clk_i);
      dsp_offset_i     <= 8'h80;
      dsp_phase_corr_i <= 8'h05;
      wr(12'h054, 32'h0000_8000, 4'hF);
      ack(1'b0);
      rdr(12'h054);
      chk("long term offset", 32'h0000_0080, rd);
      @(posedge ref_clk_i);
      dsp_offset_i     <= 8'h7F;
      dsp_phase_corr_i <= 8'hFB;
      wr(12'h054, 32'h0000_FF00, 4'hF);
      ack(1'b1);
      rdr(12'h054);
      chk("control value", 32'h0000_017A, rd);
      @(posedge ref_clk_i);
      dsp_offset_i <= 8'h11;
      wr(12'h054, 32'h0000_8000, 4'h1);
      repeat (4) @(posedge ref_clk_i);
      chk("no fetch low strobe", 32'h0, {31'h0, dsp_req_o});
      rdr(12'h054);
      chk("offset held", 32'h0000_017A, rd);
      $display("test freq done");
   endtask : t_freq
   // Reset for three cycles, then run every scenario.
   initial begin
      errors = 0;
      compares = 0;
      rst_i = 1'b1;
      {s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
      {link_up_i, speed_100_i, length_estimate_valid_i, dsp_ack_i} = '0;
      {s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, s_axi_wstrb_i} = '0;
      {length_estimate_i, dsp_offset_i, dsp_phase_corr_i} = '0;
      repeat (3) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_page();
      t_length();
      t_freq();
      end_of_test();
   end
endmodule : ldf_regs_tb
`default_nettype wire
